/* File: verilog/tgah_pkg.sv */
// Constants and types for the train gating, axle and heat alarm block
package tgah_pkg;

    // Clock and times in their own units, then in cycles
    localparam longint unsigned CLK_HZ       = 125_000_000;
    localparam longint unsigned CLK_MHZ      = 125;
    localparam longint unsigned MIN_PULSE_US = 3000;
    localparam logic [31:0]     MIN_PULSE_CYC = 32'(MIN_PULSE_US * CLK_MHZ);
    localparam longint unsigned QUIET_S      = 10;
    localparam logic [31:0]     QUIET_CYC     = 32'(QUIET_S * CLK_HZ);

    // Track geometry and speed figures
    localparam longint unsigned SPACING_IN  = 24;
    localparam longint unsigned IN_PER_MILE = 63360;
    localparam longint unsigned SEC_PER_HR  = 3600;
    localparam longint unsigned SPEED_NUM   = SPACING_IN * CLK_HZ * SEC_PER_HR / IN_PER_MILE;
    localparam logic [31:0] PREGATE_IN  = 32'h0000_0010;
    localparam logic [31:0] SPACING_W   = 32'(SPACING_IN);
    localparam logic [31:0] SAMPLES     = 32'h0000_0030;
    localparam logic [7:0]  MAX_MPH     = 8'h63;
    localparam longint unsigned SLOW_MPH = 7;
    localparam longint unsigned THR_MPH  = 20;
    localparam logic [31:0] SLOW_TICKS  = 32'(SPEED_NUM / SLOW_MPH);
    localparam logic [31:0] THR_TICKS   = 32'(SPEED_NUM / THR_MPH);
    localparam logic [15:0] VALID_AXLES = 16'h0004;
    localparam logic [15:0] SPEED_AXLES = 16'h0008;
    localparam logic [34:0] SPEED8_NUM  = 35'(SPEED_NUM * 8);
    localparam logic [7:0]  ANNOUNCE_MAX = 8'h04;

    // Register indices
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ABS    = 4'h1;
    localparam logic [3:0] REG_DIFF   = 4'h2;
    localparam logic [3:0] REG_SLOPE  = 4'h3;
    localparam logic [3:0] REG_MINHT  = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_AXLES  = 4'h6;
    localparam logic [3:0] REG_SPEED  = 4'h7;
    localparam logic [3:0] REG_MISF   = 4'h8;
    localparam logic [3:0] REG_ALARMS = 4'h9;

    // Reset values
    localparam logic [5:0] CTRL_RST  = 6'h3E;
    localparam logic [7:0] ABS_RST   = 8'hAA;
    localparam logic [7:0] DIFF_RST  = 8'h50;
    localparam logic [7:0] SLOPE_RST = 8'h78;
    localparam logic [7:0] MINHT_RST = 8'h3C;

    typedef enum logic {
        ST_IDLE   = 1'b0,
        ST_ACTIVE = 1'b1
    } tgah_state_t;

    typedef struct packed {
        logic say_cars;
        logic say_length;
        logic say_speed;
        logic say_axles;
        logic say_slow;
        logic slope_en;
    } tgah_ctrl_t;

    typedef struct packed {
        logic [7:0] side_b;
        logic [7:0] side_a;
    } tgah_heat_t;

    typedef struct packed {
        logic [1:0] slope_hit;
        logic [1:0] sat_hit;
        logic [1:0] diff_hit;
        logic [1:0] abs_hit;
    } tgah_alarm_t;

    typedef struct packed {
        logic say_cars;
        logic say_length;
        logic say_speed;
        logic say_axles;
        logic too_slow;
        logic valid;
    } tgah_post_t;

endpackage

/* File: verilog/tgah_detector.sv */
// Train detection, gate pulse validation, axle/speed and bearing heat alarms
`timescale 1ns/1ps

// What this block does
// - On presence, activate, open shutters, heaters off
// - Train valid only after four axles
// - Track cause: ten seconds absent deactivates
// - Sensor cause: ten seconds no gate activity
// - Exit speed from last eight axle transits
// - Speeds above 99 mph report as 99
// - Fewer than eight axles reports zero speed
// - Below 7 mph no differential/saturation/slope alarms
// - Slow train: flag, suppress count/speed announcements
// - Direction from sensor giving first pulse
// - Low threshold under 20 mph, high above
// - Rising edge starts width timer, falling stops
// - Pulses under 3 ms dropped, no counting
// - Repeat pulse on one sensor bumps misfire
// - Axle counts on alternating valid pulse pair
// - Scan from first centre, later 16 in earlier
// - 48 half-inch samples, keep the maximum
// - Record all alarms, announce first four only
// - Absolute alarm above offset always checked
// - Differential alarm versus opposite bearing
// - Saturation on interaxle sample unless prior alarm
// - Carside slope when enabled, unless prior alarm
module tgah_detector #(
    parameter logic [31:0] MIN_PULSE_CYC = tgah_pkg::MIN_PULSE_CYC,
    parameter logic [31:0] QUIET_CYC     = tgah_pkg::QUIET_CYC
) (
    // Clock and reset
    input  logic                  clock,
    input  logic                  sys_rst,
    // Pins from comparators and presence detectors
    input  logic                  near_gate_input_line,
    input  logic                  far_gate_input_line,
    input  logic                  track_presence,
    input  logic                  advance_presence,
    // Scanner side
    input  tgah_pkg::tgah_heat_t  heat,
    output logic                  shutter_open,
    output logic                  heater_off,
    output logic                  comparator_thr_high,
    output logic                  scan_window,
    output logic                  sample_req,
    // Alarm reporting
    output logic                  alarm_valid,
    output logic                  alarm_announce,
    output tgah_pkg::tgah_alarm_t alarm_kind,
    output logic [15:0]           alarm_axle,
    // Train reporting
    output logic                  train_active,
    output logic                  train_valid,
    output logic                  direction_far,
    output logic                  train_done,
    output tgah_pkg::tgah_post_t  post_flags,
    // Register port
    input  logic [3:0]            reg_addr,
    input  logic [15:0]           reg_wdata,
    input  logic                  reg_wr,
    input  logic                  reg_rd,
    output logic [15:0]           reg_rdata
);

    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        return (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
    endfunction

    function automatic logic [7:0] speed_of(input logic [34:0] sum);
        logic [34:0] q;
        q = (sum == 35'h0) ? 35'h0 : tgah_pkg::SPEED8_NUM / sum;
        return (q > {27'h0, tgah_pkg::MAX_MPH}) ? tgah_pkg::MAX_MPH : q[7:0];
    endfunction

    // Raw per-side checks: {slope, sat, diff, abs}
    function automatic logic [3:0] side_chk(input logic [7:0] x, input logic [7:0] opp,
                                            input logic [7:0] ix, input logic [7:0] lim,
                                            input logic [7:0] dl, input logic [7:0] lvl,
                                            input logic [7:0] mn);
        logic [3:0] r;
        r[0] = x > lim;
        r[1] = {1'b0, x} > ({1'b0, opp} + {1'b0, dl});
        r[2] = ix > lim;
        r[3] = (x >= lvl) && (x >= mn) && ({1'b0, x} >= {opp, 1'b0});
        return r;
    endfunction

    // Pin synchronisers, first stage feeds only the second
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [1:0] gate_d_reg;
    always_ff @(posedge clock) begin
        pin_meta_reg <= {advance_presence, track_presence, far_gate_input_line,
                         near_gate_input_line};
        pin_sync_reg <= pin_meta_reg;
        gate_d_reg   <= sys_rst ? 2'b00 : pin_sync_reg[1:0];
    end

    wire [1:0] gate_s   = pin_sync_reg[1:0];
    wire       track_s  = pin_sync_reg[2];
    wire       adv_s    = pin_sync_reg[3];
    wire [1:0] rise     = gate_s & ~gate_d_reg;
    wire [1:0] fall     = ~gate_s & gate_d_reg;
    wire       gate_act = |(rise | fall);

    // Pulse width timers
    logic [31:0] width_reg [2];
    always_ff @(posedge clock) begin
        for (int i = 0; i < 2; i++) begin
            if (sys_rst)
                width_reg[i] <= 32'h0;
            else if (rise[i])
                width_reg[i] <= 32'h0000_0001;
            else if (gate_s[i])
                width_reg[i] <= sat_inc(width_reg[i]);
        end
    end
    wire [1:0] width_ok = {width_reg[1] >= MIN_PULSE_CYC, width_reg[0] >= MIN_PULSE_CYC};
    wire [1:0] vpulse   = fall & width_ok;

    // Registers written by software
    tgah_pkg::tgah_ctrl_t ctrl_reg;
    logic [7:0] abs_reg, diff_reg, slope_reg, minht_reg;

    // Activation
    tgah_pkg::tgah_state_t state_reg, state_next;
    logic        cause_track_reg;
    logic [31:0] quiet_reg;
    wire presence  = track_s | adv_s | (|gate_s);
    wire start     = (state_reg == tgah_pkg::ST_IDLE) && presence;
    wire hold      = cause_track_reg ? track_s : gate_act;
    wire deact     = (state_reg == tgah_pkg::ST_ACTIVE) && !hold
                     && (quiet_reg >= QUIET_CYC - 32'h1);
    wire active    = state_reg == tgah_pkg::ST_ACTIVE;

    always_comb begin
        unique case (state_reg)
            tgah_pkg::ST_IDLE:   state_next = presence ? tgah_pkg::ST_ACTIVE : tgah_pkg::ST_IDLE;
            tgah_pkg::ST_ACTIVE: state_next = deact ? tgah_pkg::ST_IDLE : tgah_pkg::ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg       <= tgah_pkg::ST_IDLE;
            cause_track_reg <= 1'b0;
            quiet_reg       <= 32'h0;
        end else begin
            state_reg <= state_next;
            if (start)
                cause_track_reg <= track_s | adv_s;
            quiet_reg <= (start || hold) ? 32'h0 : sat_inc(quiet_reg);
        end
    end

    // Direction and wheel sequencing
    logic        dir_valid_reg, dir_reg, wheel_open_reg;
    logic [15:0] axle_reg;
    logic [7:0]  misf_reg [2];
    wire first_ev  = dir_valid_reg ? vpulse[dir_reg] : |vpulse;
    wire first_idx = dir_valid_reg ? dir_reg : ~vpulse[0];
    wire second_ev = dir_valid_reg & vpulse[~dir_reg];
    wire axle_ev   = second_ev & wheel_open_reg;
    wire mis_first = first_ev & wheel_open_reg;
    wire mis_sec   = second_ev & ~wheel_open_reg;
    wire open_ev   = first_ev & ~wheel_open_reg;

    always_ff @(posedge clock) begin
        if (sys_rst || start) begin
            dir_valid_reg  <= 1'b0;
            dir_reg        <= 1'b0;
            wheel_open_reg <= 1'b0;
            axle_reg       <= 16'h0;
            misf_reg[0]    <= 8'h0;
            misf_reg[1]    <= 8'h0;
        end else if (active) begin
            if (first_ev && !dir_valid_reg) begin
                dir_valid_reg <= 1'b1;
                dir_reg       <= first_idx;
            end
            if (open_ev)
                wheel_open_reg <= 1'b1;
            else if (axle_ev)
                wheel_open_reg <= 1'b0;
            if (axle_ev)
                axle_reg <= axle_reg + 16'h1;
            if (mis_first && misf_reg[first_idx] != 8'hFF)
                misf_reg[first_idx] <= misf_reg[first_idx] + 8'h1;
            if (mis_sec && misf_reg[~dir_reg] != 8'hFF)
                misf_reg[~dir_reg] <= misf_reg[~dir_reg] + 8'h1;
        end
    end

    // Transit and wheel period timing in ticks
    logic [31:0] transit_reg, period_reg, last_tr_reg, last_per_reg;
    logic [31:0] ring_reg [8];
    logic [2:0]  ring_idx_reg;
    logic [34:0] sum_reg;
    logic [7:0]  speed_reg;
    logic        slow_reg, thr_reg;
    wire [34:0] sum_next = sum_reg - {3'h0, ring_reg[ring_idx_reg]} + {3'h0, transit_reg};
    wire        slow_now = transit_reg > tgah_pkg::SLOW_TICKS;
    wire        slow_eff = slow_reg | slow_now;

    always_ff @(posedge clock) begin
        if (sys_rst || start) begin
            transit_reg  <= 32'h0;
            period_reg   <= 32'h0;
            last_tr_reg  <= 32'h0;
            last_per_reg <= 32'h0;
            ring_idx_reg <= 3'h0;
            sum_reg      <= 35'h0;
            speed_reg    <= 8'h0;
            slow_reg     <= 1'b0;
            thr_reg      <= 1'b0;
            for (int i = 0; i < 8; i++)
                ring_reg[i] <= 32'h0;
        end else begin
            transit_reg <= open_ev ? 32'h0 : sat_inc(transit_reg);
            period_reg  <= open_ev ? 32'h0 : sat_inc(period_reg);
            if (open_ev)
                last_per_reg <= period_reg;
            if (axle_ev) begin
                last_tr_reg            <= transit_reg;
                ring_reg[ring_idx_reg] <= transit_reg;
                ring_idx_reg           <= ring_idx_reg + 3'h1;
                sum_reg                <= sum_next;
                speed_reg <= (axle_reg + 16'h1 >= tgah_pkg::SPEED_AXLES)
                             ? speed_of(sum_next) : 8'h0;
                slow_reg  <= slow_eff;
                thr_reg   <= transit_reg < tgah_pkg::THR_TICKS;
            end
        end
    end

    // Scan window and half-inch sampling
    wire [31:0] pre_len  = 32'(({32'h0, last_tr_reg} * {32'h0, tgah_pkg::PREGATE_IN})
                              / {32'h0, tgah_pkg::SPACING_W});
    wire [31:0] pre_at   = (last_per_reg > pre_len) ? last_per_reg - pre_len : 32'h0;
    wire        pregate  = (axle_reg != 16'h0) && !wheel_open_reg && (period_reg >= pre_at);
    wire        scan_on  = active && (wheel_open_reg || pregate);
    wire [31:0] samp_q   = last_tr_reg / tgah_pkg::SAMPLES;
    wire [31:0] samp_int = (samp_q == 32'h0) ? 32'h1 : samp_q;
    logic [31:0] samp_cnt_reg;
    logic        samp_reg;
    tgah_pkg::tgah_heat_t max_reg, inter_reg;
    wire samp_hit = scan_on && (samp_cnt_reg >= samp_int - 32'h1);

    always_ff @(posedge clock) begin
        if (sys_rst || start || !scan_on || open_ev)
            samp_cnt_reg <= 32'h0;
        else
            samp_cnt_reg <= samp_hit ? 32'h0 : samp_cnt_reg + 32'h1;
        samp_reg <= !sys_rst && samp_hit;
    end

    // Hold maxima: wheel between centres, interaxle before the gate
    always_ff @(posedge clock) begin
        if (sys_rst || start || open_ev)
            max_reg <= '0;
        else if (samp_reg && wheel_open_reg) begin
            if (heat.side_a > max_reg.side_a) max_reg.side_a <= heat.side_a;
            if (heat.side_b > max_reg.side_b) max_reg.side_b <= heat.side_b;
        end
        if (sys_rst || start || axle_ev)
            inter_reg <= '0;
        else if (samp_reg && !wheel_open_reg) begin
            if (heat.side_a > inter_reg.side_a) inter_reg.side_a <= heat.side_a;
            if (heat.side_b > inter_reg.side_b) inter_reg.side_b <= heat.side_b;
        end
    end

    // Alarm decisions at each completed axle
    wire [3:0] chk_a = side_chk(max_reg.side_a, max_reg.side_b, inter_reg.side_a, abs_reg,
                                diff_reg, slope_reg, minht_reg);
    wire [3:0] chk_b = side_chk(max_reg.side_b, max_reg.side_a, inter_reg.side_b, abs_reg,
                                diff_reg, slope_reg, minht_reg);
    wire [1:0] abs_h   = {chk_b[0], chk_a[0]};
    wire [1:0] diff_h  = {chk_b[1], chk_a[1]} & {2{~slow_eff}};
    wire       primary = |abs_h | |diff_h;
    wire [1:0] sat_h   = {chk_b[2], chk_a[2]} & {2{~slow_eff & ~primary}};
    wire [1:0] slope_h = {chk_b[3], chk_a[3]}
                         & {2{ctrl_reg.slope_en & ~slow_eff & ~primary}};
    wire       any_hit = primary | (|sat_h) | (|slope_h);
    logic [7:0] alarm_cnt_reg;

    always_ff @(posedge clock) begin
        if (sys_rst || start) begin
            alarm_valid    <= 1'b0;
            alarm_announce <= 1'b0;
            alarm_kind     <= '0;
            alarm_axle     <= 16'h0;
            alarm_cnt_reg  <= 8'h0;
        end else begin
            alarm_valid    <= axle_ev && any_hit;
            alarm_announce <= axle_ev && any_hit
                              && alarm_cnt_reg < tgah_pkg::ANNOUNCE_MAX;
            if (axle_ev && any_hit) begin
                alarm_kind <= {slope_h, sat_h, diff_h, abs_h};
                alarm_axle <= axle_reg + 16'h1;
                if (alarm_cnt_reg != 8'hFF)
                    alarm_cnt_reg <= alarm_cnt_reg + 8'h1;
            end
        end
    end

    // End of train summary
    wire is_valid = axle_reg >= tgah_pkg::VALID_AXLES;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            train_done <= 1'b0;
            post_flags <= '0;
        end else begin
            train_done <= deact;
            if (deact) begin
                post_flags.valid      <= is_valid;
                post_flags.too_slow   <= slow_reg & ctrl_reg.say_slow;
                post_flags.say_axles  <= ctrl_reg.say_axles & ~slow_reg & is_valid;
                post_flags.say_speed  <= ctrl_reg.say_speed & ~slow_reg & is_valid;
                post_flags.say_length <= ctrl_reg.say_length & ~slow_reg & is_valid;
                post_flags.say_cars   <= ctrl_reg.say_cars & ~slow_reg & is_valid;
            end
        end
    end

    assign shutter_open        = active;
    assign heater_off          = active;
    assign train_active        = active;
    assign train_valid         = active && is_valid;
    assign direction_far       = dir_reg;
    assign comparator_thr_high = thr_reg;
    assign scan_window         = scan_on;
    assign sample_req          = samp_reg;

    // Register port
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_reg  <= tgah_pkg::CTRL_RST;
            abs_reg   <= tgah_pkg::ABS_RST;
            diff_reg  <= tgah_pkg::DIFF_RST;
            slope_reg <= tgah_pkg::SLOPE_RST;
            minht_reg <= tgah_pkg::MINHT_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                tgah_pkg::REG_CTRL:  ctrl_reg  <= reg_wdata[5:0];
                tgah_pkg::REG_ABS:   abs_reg   <= reg_wdata[7:0];
                tgah_pkg::REG_DIFF:  diff_reg  <= reg_wdata[7:0];
                tgah_pkg::REG_SLOPE: slope_reg <= reg_wdata[7:0];
                tgah_pkg::REG_MINHT: minht_reg <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    logic [15:0] rd_mux;
    always_comb begin
        case (reg_addr)
            tgah_pkg::REG_CTRL:   rd_mux = {10'h0, ctrl_reg};
            tgah_pkg::REG_ABS:    rd_mux = {8'h0, abs_reg};
            tgah_pkg::REG_DIFF:   rd_mux = {8'h0, diff_reg};
            tgah_pkg::REG_SLOPE:  rd_mux = {8'h0, slope_reg};
            tgah_pkg::REG_MINHT:  rd_mux = {8'h0, minht_reg};
            tgah_pkg::REG_STATUS: rd_mux = {10'h0, thr_reg, slow_reg, dir_reg, is_valid,
                                            cause_track_reg, active};
            tgah_pkg::REG_AXLES:  rd_mux = axle_reg;
            tgah_pkg::REG_SPEED:  rd_mux = {8'h0, speed_reg};
            tgah_pkg::REG_MISF:   rd_mux = {misf_reg[1], misf_reg[0]};
            tgah_pkg::REG_ALARMS: rd_mux = {8'h0, alarm_cnt_reg};
            default:              rd_mux = 16'h0;
        endcase
    end

    always_ff @(posedge clock) begin
        reg_rdata <= (sys_rst || !reg_rd) ? 16'h0 : rd_mux;
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_short;
        active && (|(fall & ~width_ok)) && !(|vpulse);
    endsequence
    sequence s_seen_train;
        start ##1 active;
    endsequence

    activate_a: assert property (start |=> shutter_open && heater_off)
        else $error("presence did not activate the scanners");
    valid_four_a: assert property ($rose(train_valid) |-> axle_reg == 16'h4)
        else $error("train marked valid at wrong axle count");
    track_hold_a: assert property (active && cause_track_reg && track_s |=> active)
        else $error("deactivated while track circuit present");
    gate_hold_a: assert property (active && !cause_track_reg && gate_act |=> active)
        else $error("deactivated despite gate activity");
    speed_clamp_a: assert property (axle_ev |=> speed_reg <= 8'h63)
        else $error("reported speed above limit");
    few_axles_a: assert property (axle_reg < 16'h8 |-> speed_reg == 8'h0)
        else $error("speed reported for short train");
    slow_quiet_a: assert property (alarm_valid && slow_reg |->
        alarm_kind.diff_hit == 2'b00 && alarm_kind.sat_hit == 2'b00
        && alarm_kind.slope_hit == 2'b00)
        else $error("speed gated alarm on slow train");
    short_drop_a: assert property (s_short |=> $stable(axle_reg)
        && $stable(misf_reg[0]) && $stable(misf_reg[1]))
        else $error("short pulse was counted");
    first_dir_a: assert property (active && !dir_valid_reg && vpulse[1] && !vpulse[0]
        |=> direction_far)
        else $error("direction not taken from first pulse");
    announce_cap_a: assert property (alarm_announce |-> alarm_cnt_reg <= 8'h4)
        else $error("more than four alarms announced");
    fresh_train_a: assert property (s_seen_train |-> axle_reg == 16'h0
        && speed_reg == 8'h0)
        else $error("train counters not cleared at activation");

endmodule

/* File: bench/tgah_gate_model.sv */
// Model of the gating sensors and the track circuit ahead of the detector
`timescale 1ns/1ps
module tgah_gate_model (
    // Clock
    input  logic       clock,
    // Comparator outputs and presence lines
    output logic       near_line,
    output logic       far_line,
    output logic       track,
    output logic       advance
);
    logic [1:0] lines = 2'h0;
    assign near_line = lines[0];
    assign far_line  = lines[1];
    // Advance detector line, raised only by the advance test
    logic adv_q = 1'b0;
    assign advance   = adv_q;
    initial begin
        track = 1'b0;
    end
    // One comparator pulse of w cycles, then g quiet cycles
    task automatic pulse(input bit far_sel, input int w, input int g);
        @(posedge clock);
        lines[far_sel] <= 1'b1;
        repeat (w) @(posedge clock);
        lines[far_sel] <= 1'b0;
        repeat (g) @(posedge clock);
    endtask
    // One wheel crosses both gates in the order of travel
    task automatic wheel(input bit far_first, input int w, input int g);
        pulse(far_first, w, g);
        pulse(!far_first, w, g);
    endtask
    task automatic set_track(input logic v);
        @(posedge clock);
        track <= v;
    endtask
    task automatic set_adv(input logic v);
        @(posedge clock);
        adv_q <= v;
    endtask
endmodule

/* File: bench/test_train_gating_axle_and_heat_alarm.sv */
// Self-checking bench for the gating, axle and heat alarm detector
`timescale 1ns/1ps
module test_train_gating_axle_and_heat_alarm;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic near_l, far_l, trk, adv;
    tgah_pkg::tgah_heat_t heat = 16'h0000;
    tgah_pkg::tgah_alarm_t kind;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, v;
    logic wr = 1'b0, rd = 1'b0;
    logic shut, htr, alv, ann, act, tval, dfar, done, thr, scw, sreq;
    logic [15:0] axl;
    tgah_pkg::tgah_post_t post;
    int nsmp = 0, nscan = 0;
    logic [31:0] seed = 32'h8848D8E0;
    int err_total = 0, checked = 0, cyc = 0, n, exp_alarms = 0, anns = 0;
    tgah_gate_model i_gate (.clock(clock), .near_line(near_l), .far_line(far_l),
        .track(trk), .advance(adv));
    tgah_detector #(.MIN_PULSE_CYC(32'h0000_0014), .QUIET_CYC(32'h0000_00C8)) i_dut (
        .clock(clock), .sys_rst(sys_rst), .near_gate_input_line(near_l),
        .far_gate_input_line(far_l), .track_presence(trk), .advance_presence(adv),
        .heat(heat), .shutter_open(shut), .heater_off(htr), .comparator_thr_high(thr),
        .scan_window(scw), .sample_req(sreq), .alarm_valid(alv), .alarm_announce(ann),
        .alarm_kind(kind), .alarm_axle(axl), .train_active(act), .train_valid(tval),
        .direction_far(dfar), .train_done(done), .post_flags(post), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    initial begin
        forever #4 clock = ~clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Hot side a on every bearing, random cooler side b
    always @(posedge clock) begin
        seed <= lfsr(seed);
        heat <= {seed[7:0] & 8'h7F, 8'hFF};
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    // Outputs are looked at mid-cycle, where they have settled
    always @(negedge clock) begin
        if (alv === 1'b1) begin
            exp_alarms++;
            chk("abs_hit", 16'h0001, {14'h0, kind.abs_hit});
        end
        if (ann === 1'b1) anns++;
        if (sreq === 1'b1) nsmp++;
        if (scw === 1'b1) nscan++;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        d = rdata;
        @(posedge clock);
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // Counts cycles from the call until the done pulse, giving up after 2000
    task automatic wait_done();
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (done !== 1'b1 && n < 2000);
        @(posedge clock);
        chk("quiet_ok", 16'h0001, {15'h0, n >= 190 && n <= 215});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        reg_rd(tgah_pkg::REG_CTRL, v);
        chk("ctrl_rst", 16'h003E, v);
        reg_wr(tgah_pkg::REG_ABS, 16'hFFC0);
        reg_rd(tgah_pkg::REG_ABS, v);
        chk("abs_rw", 16'h00C0, v);
        reg_rd(4'hF, v);
        chk("unmapped", 16'h0000, v);
        $display("test registers done");
        i_gate.pulse(1'b0, 8, 5);
        chk("shutter", 16'h0003, {14'h0, shut, htr});
        reg_rd(tgah_pkg::REG_AXLES, v);
        chk("axles_short", 16'h0000, v);
        i_gate.pulse(1'b0, 25, 5);
        i_gate.pulse(1'b0, 25, 5);
        i_gate.pulse(1'b1, 25, 5);
        repeat (3) i_gate.wheel(1'b0, 25, 5);
        chk("valid", 16'h0002, {14'h0, tval, dfar});
        reg_rd(tgah_pkg::REG_MISF, v);
        chk("misfire", 16'h0001, v);
        reg_rd(tgah_pkg::REG_AXLES, v);
        chk("axles", 16'h0004, v);
        wait_done();
        reg_rd(tgah_pkg::REG_SPEED, v);
        chk("speed_short", 16'h0000, v);
        chk("ann1", 16'h0004, 16'(anns));
        chk("last_axle1", 16'h0004, axl);
        chk("post_gate", 16'h003D, {10'h0, post});
        $display("test gate train done");
        i_gate.set_track(1'b1);
        repeat (6) @(posedge clock);
        chk("track_act", 16'h0001, {15'h0, act});
        repeat (8) i_gate.wheel(1'b1, 25, 5);
        chk("dir_far", 16'h0001, {15'h0, dfar});
        i_gate.set_track(1'b0);
        wait_done();
        reg_rd(tgah_pkg::REG_SPEED, v);
        chk("speed_clamp", 16'h0063, v);
        reg_rd(tgah_pkg::REG_ALARMS, v);
        chk("alarm_count", 16'(exp_alarms - 4), v);
        chk("ann2", 16'h0008, 16'(anns));
        chk("last_axle2", 16'h0008, axl);
        chk("post_track", 16'h003D, {10'h0, post});
        reg_rd(tgah_pkg::REG_STATUS, v);
        chk("status", 16'h002E, v);
        chk("thr_high", 16'h0001, {15'h0, thr});
        chk("samples", 16'h0001, {15'h0, nsmp > 0 && nsmp <= nscan});
        $display("test track train done");
        i_gate.set_adv(1'b1);
        repeat (6) @(posedge clock);
        chk("adv_act", 16'h0001, {15'h0, act});
        i_gate.set_adv(1'b0);
        wait_done();
        chk("post_adv", 16'h0000, {10'h0, post});
        $display("test advance train done");
        stop_test();
    end
endmodule
